// *** pms_host_model.sv ***
// Purpose: Behavioural host that reads and writes the status block.
// Assumes: One request at a time, each strobe lasting one clock, except reg_read_pair, which holds rd_en_o for two.
// Notes: Released command and data lines show the inverse of the last value.
`timescale 1ns/100ps
module pms_host_model (
   input wire logic clk_i,
   input wire logic [15:0] rd_data_i,
   input wire logic rd_valid_i,
   input wire logic rd_hit_i,
   output logic [7:0] cmd_o,
   output logic wr_en_o,
   output logic [15:0] wr_data_o,
   output logic rd_en_o,
   output logic comm_err_o
);
   initial begin
      cmd_o = 8'h00;
      wr_en_o = 1'b0;
      wr_data_o = 16'h0000;
      rd_en_o = 1'b0;
      comm_err_o = 1'b0;
   end

   // The answer is registered, so it is taken at the edge after launch.
   task automatic reg_read(input logic [7:0] c, output logic [15:0] d,
         output logic v, output logic h);
      @(posedge clk_i);
      cmd_o <= c;
      rd_en_o <= 1'b1;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      cmd_o <= ~c;
      @(posedge clk_i);
      d = rd_data_i;
      v = rd_valid_i;
      h = rd_hit_i;
   endtask : reg_read

   // Two reads on consecutive edges; each word is taken at the edge
   // after the one that launched it.
   task automatic reg_read_pair(input logic [7:0] c0, input logic [7:0] c1,
         output logic [15:0] d0, output logic [15:0] d1);
      @(posedge clk_i);
      cmd_o <= c0;
      rd_en_o <= 1'b1;
      @(posedge clk_i);
      cmd_o <= c1;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      cmd_o <= ~c1;
      d0 = rd_data_i;
      @(posedge clk_i);
      d1 = rd_data_i;
   endtask : reg_read_pair

   task automatic reg_write(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_i);
      cmd_o <= c;
      wr_data_o <= d;
      wr_en_o <= 1'b1;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      cmd_o <= ~c;
      wr_data_o <= ~d;
   endtask : reg_write

   // A frame with a bad check byte, as the serial engine reports it.
   task automatic bad_frame();
      @(posedge clk_i);
      comm_err_o <= 1'b1;
      @(posedge clk_i);
      comm_err_o <= 1'b0;
   endtask : bad_frame
endmodule : pms_host_model

// *** pms_pkg.sv ***
// Purpose: Constants shared by the power monitor status flag block.
// Assumes: Command codes are the byte addresses seen by the serial engine.
// Notes: Thresholds and readings use the direct-format readback coding.
package pms_pkg;

   // Command codes of the registers held or decoded here.
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OVERPOWER_THRESHOLD = 8'h6b;
   localparam logic [7:0] CMD_SUMMARY_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_SUMMARY_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_CURRENT_WARNING_STATUS = 8'h7b;
   localparam logic [7:0] CMD_INPUT_WARNING_STATUS = 8'h7c;
   localparam logic [7:0] CMD_VENDOR_AUX_WARNING_STATUS = 8'h80;

   // Values after reset.
   localparam logic [15:0] OVERPOWER_THRESHOLD_RST = 16'h7fff;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [15:0] RD_DATA_RST = 16'h0000;

   // Threshold codes that switch a comparison off.
   localparam logic [15:0] OVERPOWER_DISABLE = 16'h7fff;
   localparam logic [11:0] OVERCURRENT_DISABLE = 12'h7ff;
   localparam logic [11:0] OVERVOLTAGE_DISABLE = 12'hfff;
   localparam logic [11:0] UNDERVOLTAGE_DISABLE = 12'h000;

   // Bit positions in the summary byte and word.
   localparam int SUM_OTHER_PENDING_BIT = 0;
   localparam int SUM_COMM_ERROR_BIT = 1;
   localparam int SUM_VENDOR_BIT = 12;
   localparam int SUM_INPUT_BIT = 13;
   localparam int SUM_CURRENT_BIT = 14;

   // Bit positions in the category warning registers.
   localparam int CUR_OVERCURRENT_BIT = 5;
   localparam int INP_OVERVOLTAGE_BIT = 6;
   localparam int INP_UNDERVOLTAGE_BIT = 5;
   localparam int INP_OVERPOWER_BIT = 0;
   localparam int VEN_OVERVOLTAGE_BIT = 6;
   localparam int VEN_UNDERVOLTAGE_BIT = 5;

endpackage : pms_pkg

// *** pms_status_flags.sv ***
// Purpose: Warning comparisons and status registers of a power monitor.
// Assumes: Command, data and measurement inputs come from logic on clk_i.
// Notes: Reads answer one cycle after rd_en_i on rd_data_o with rd_valid_o.
`timescale 1ns/100ps

// Summary of operation
// R1 - Overpower threshold is signed, sign picks direction.
// R2 - Overpower threshold 16-bit RW, 0x7fff disables.
// R3 - Summary byte equals low byte of word.
// R4 - A one bit means warning occurred.
// R5 - Comm error bit 1 latches on bus errors.
// R6 - Byte bit 0 live: other register active.
// R7 - Word bit 14 live: current register active.
// R8 - Word bit 13 live: input register active.
// R9 - Word bit 12 live: vendor register active.
// R10 - Word bits 15, 11:8, byte 7:2 read zero.
// R11 - Current bit 5 latches on overcurrent.
// R12 - Input bit 6 latches on overvoltage.
// R13 - Input bit 5 latches on undervoltage.
// R14 - Input bit 0 latches on overpower.
// R15 - Reserved bits of warning registers read zero.
// R16 - Clear-faults clears all latched bits.
// R17 - Vendor register latches auxiliary OV and UV.
// R18 - Compare once per averaged measurement update.
// R19 - Latched bits hold; reads never clear them.
// R20 - Reset zeroes status, threshold to 0x7fff.
module pms_status_flags (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] cmd_i,
   input wire logic wr_en_i,
   input wire logic [15:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic comm_err_i,
   input wire logic sample_valid_i,
   input wire logic [11:0] sensed_current_i,
   input wire logic [11:0] primary_voltage_i,
   input wire logic [15:0] power_i,
   input wire logic [11:0] auxiliary_voltage_i,
   input wire logic [11:0] overcurrent_threshold_i,
   input wire logic [11:0] primary_overvoltage_threshold_i,
   input wire logic [11:0] primary_undervoltage_threshold_i,
   input wire logic [11:0] aux_overvoltage_threshold_i,
   input wire logic [11:0] aux_undervoltage_threshold_i,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   output logic rd_hit_o
);

   // A signed limit flags readings beyond it, away from zero.
   function automatic logic crossed(input logic [15:0] value,
                                    input logic [15:0] limit);
      logic res;
      res = 1'b0;
      if (limit[15]) begin
         res = $signed(value) < $signed(limit);
      end else begin
         res = $signed(value) > $signed(limit);
      end
      return res;
   endfunction : crossed

   logic [15:0] overpower_threshold_ff;
   logic comm_error_flag_ff;
   logic overcurrent_flag_ff;
   logic primary_overvoltage_flag_ff;
   logic primary_undervoltage_flag_ff;
   logic overpower_flag_ff;
   logic aux_overvoltage_flag_ff;
   logic aux_undervoltage_flag_ff;
   logic [7:0] rd_cmd_ff;

   logic clear_faults;
   logic [15:0] current_ext;
   logic [15:0] oc_limit_ext;
   logic overcurrent_event;
   logic primary_overvoltage_event;
   logic primary_undervoltage_event;
   logic overpower_event;
   logic aux_overvoltage_event;
   logic aux_undervoltage_event;
   logic [7:0] current_warning_status;
   logic [7:0] input_warning_status;
   logic [7:0] vendor_aux_warning_status;
   logic current_summary_bit;
   logic input_summary_bit;
   logic vendor_summary_bit;
   logic other_status_pending;
   logic [7:0] summary_status_byte;
   logic [15:0] summary_status_word;
   logic [15:0] nxt_rd_data;
   logic nxt_rd_hit;

   // Clear-faults carries no data, so a write of the code alone acts.
   assign clear_faults = wr_en_i && (cmd_i == pms_pkg::CMD_CLEAR_FAULTS);

   // Current limit and reading share the 12-bit signed direct coding.
   assign current_ext = {{4{sensed_current_i[11]}}, sensed_current_i};
   assign oc_limit_ext = {{4{overcurrent_threshold_i[11]}},
                          overcurrent_threshold_i};

   // Events are qualified by the averaged update strobe and by the threshold not being its disable code.
   always_comb begin
      overcurrent_event = sample_valid_i // see R18
         && (overcurrent_threshold_i != pms_pkg::OVERCURRENT_DISABLE)
         && crossed(current_ext, oc_limit_ext); // see R11
      primary_overvoltage_event = sample_valid_i
         && (primary_overvoltage_threshold_i
             != pms_pkg::OVERVOLTAGE_DISABLE)
         && (primary_voltage_i > primary_overvoltage_threshold_i); // see R12
      primary_undervoltage_event = sample_valid_i
         && (primary_undervoltage_threshold_i
             != pms_pkg::UNDERVOLTAGE_DISABLE)
         && (primary_voltage_i < primary_undervoltage_threshold_i); // see R13
      overpower_event = sample_valid_i
         && (overpower_threshold_ff != pms_pkg::OVERPOWER_DISABLE) // see R2
         && crossed(power_i, overpower_threshold_ff); // see R1
      aux_overvoltage_event = sample_valid_i
         && (aux_overvoltage_threshold_i != pms_pkg::OVERVOLTAGE_DISABLE)
         && (auxiliary_voltage_i > aux_overvoltage_threshold_i); // see R17
      aux_undervoltage_event = sample_valid_i
         && (aux_undervoltage_threshold_i != pms_pkg::UNDERVOLTAGE_DISABLE)
         && (auxiliary_voltage_i < aux_undervoltage_threshold_i); // see R17
   end

   // Overpower threshold register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overpower_threshold_ff <= pms_pkg::OVERPOWER_THRESHOLD_RST; // see R20
      end else if (wr_en_i && (cmd_i == pms_pkg::CMD_OVERPOWER_THRESHOLD))
      begin
         overpower_threshold_ff <= wr_data_i; // see R2
      end
   end

   // Every latched flag: a new event wins over a clear in the same cycle,
   // so a warning that coincides with clear-faults is never lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comm_error_flag_ff <= 1'b0; // see R20
      end else begin
         comm_error_flag_ff <= (comm_error_flag_ff && !clear_faults) // see R16
            || comm_err_i; // see R5
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overcurrent_flag_ff <= 1'b0;
      end else begin
         overcurrent_flag_ff <= (overcurrent_flag_ff && !clear_faults) // see R19
            || overcurrent_event; // see R11
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         primary_overvoltage_flag_ff <= 1'b0;
         primary_undervoltage_flag_ff <= 1'b0;
         overpower_flag_ff <= 1'b0;
      end else begin
         primary_overvoltage_flag_ff <= (primary_overvoltage_flag_ff
            && !clear_faults) || primary_overvoltage_event; // see R12
         primary_undervoltage_flag_ff <= (primary_undervoltage_flag_ff
            && !clear_faults) || primary_undervoltage_event; // see R13
         overpower_flag_ff <= (overpower_flag_ff && !clear_faults)
            || overpower_event; // see R14
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aux_overvoltage_flag_ff <= 1'b0;
         aux_undervoltage_flag_ff <= 1'b0;
      end else begin
         aux_overvoltage_flag_ff <= (aux_overvoltage_flag_ff
            && !clear_faults) || aux_overvoltage_event; // see R17
         aux_undervoltage_flag_ff <= (aux_undervoltage_flag_ff
            && !clear_faults) || aux_undervoltage_event; // see R17
      end
   end

   // Register images; reserved bits stay zero.
   always_comb begin
      current_warning_status = pms_pkg::STATUS_RST; // see R15
      current_warning_status[pms_pkg::CUR_OVERCURRENT_BIT] =
         overcurrent_flag_ff; // see R4
      input_warning_status = pms_pkg::STATUS_RST; // see R15
      input_warning_status[pms_pkg::INP_OVERVOLTAGE_BIT] =
         primary_overvoltage_flag_ff;
      input_warning_status[pms_pkg::INP_UNDERVOLTAGE_BIT] =
         primary_undervoltage_flag_ff;
      input_warning_status[pms_pkg::INP_OVERPOWER_BIT] = overpower_flag_ff;
      vendor_aux_warning_status = pms_pkg::STATUS_RST;
      vendor_aux_warning_status[pms_pkg::VEN_OVERVOLTAGE_BIT] =
         aux_overvoltage_flag_ff; // see R17
      vendor_aux_warning_status[pms_pkg::VEN_UNDERVOLTAGE_BIT] =
         aux_undervoltage_flag_ff;
   end

   // Roll-up bits are live: they follow the latched bits, not events.
   assign current_summary_bit = |current_warning_status; // see R7
   assign input_summary_bit = |input_warning_status; // see R8
   assign vendor_summary_bit = |vendor_aux_warning_status; // see R9
   assign other_status_pending = current_summary_bit // see R6
      || input_summary_bit || vendor_summary_bit;

   always_comb begin
      summary_status_byte = pms_pkg::STATUS_RST; // see R10
      summary_status_byte[pms_pkg::SUM_OTHER_PENDING_BIT] =
         other_status_pending; // see R6
      summary_status_byte[pms_pkg::SUM_COMM_ERROR_BIT] = comm_error_flag_ff;
      summary_status_word = {8'h00, summary_status_byte}; // see R3
      summary_status_word[pms_pkg::SUM_CURRENT_BIT] = current_summary_bit;
      summary_status_word[pms_pkg::SUM_INPUT_BIT] = input_summary_bit;
      summary_status_word[pms_pkg::SUM_VENDOR_BIT] = vendor_summary_bit;
   end

   // Read multiplexer; an unknown code answers zero with rd_hit_o low.
   always_comb begin
      nxt_rd_data = pms_pkg::RD_DATA_RST;
      nxt_rd_hit = 1'b1;
      case (cmd_i)
         pms_pkg::CMD_OVERPOWER_THRESHOLD: begin
            nxt_rd_data = overpower_threshold_ff;
         end
         pms_pkg::CMD_SUMMARY_STATUS_BYTE: begin
            nxt_rd_data = {8'h00, summary_status_byte}; // see R3
         end
         pms_pkg::CMD_SUMMARY_STATUS_WORD: begin
            nxt_rd_data = summary_status_word;
         end
         pms_pkg::CMD_CURRENT_WARNING_STATUS: begin
            nxt_rd_data = {8'h00, current_warning_status};
         end
         pms_pkg::CMD_INPUT_WARNING_STATUS: begin
            nxt_rd_data = {8'h00, input_warning_status};
         end
         pms_pkg::CMD_VENDOR_AUX_WARNING_STATUS: begin
            nxt_rd_data = {8'h00, vendor_aux_warning_status};
         end
         default: begin
            nxt_rd_hit = 1'b0;
         end
      endcase
   end

   // Reads only sample the flags; clearing is left to clear-faults.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= pms_pkg::RD_DATA_RST;
         rd_valid_o <= 1'b0;
         rd_hit_o <= 1'b0;
         rd_cmd_ff <= 8'h00;
      end else begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) begin
            rd_data_o <= nxt_rd_data; // see R19
            rd_hit_o <= nxt_rd_hit;
            rd_cmd_ff <= cmd_i;
         end
      end
   end

   a_thr_reset_val: assert property ( // see R20
      @(posedge clk_i) $fell(rst_i) |-> overpower_threshold_ff
         == pms_pkg::OVERPOWER_THRESHOLD_RST && !overpower_flag_ff
         && !comm_error_flag_ff)
      else $error("Threshold or flags wrong after reset.");

   a_op_positive: assert property ( // see R1
      @(posedge clk_i) disable iff (rst_i)
      sample_valid_i && !overpower_threshold_ff[15]
         && overpower_threshold_ff != pms_pkg::OVERPOWER_DISABLE
         && $signed(power_i) > $signed(overpower_threshold_ff)
         |=> overpower_flag_ff)
      else $error("Positive overpower not flagged.");

   a_op_negative: assert property ( // see R14
      @(posedge clk_i) disable iff (rst_i)
      sample_valid_i && overpower_threshold_ff[15]
         && $signed(power_i) < $signed(overpower_threshold_ff)
         |=> input_warning_status[pms_pkg::INP_OVERPOWER_BIT])
      else $error("Negative overpower not flagged.");

   a_op_disabled: assert property ( // see R2
      @(posedge clk_i) disable iff (rst_i)
      !overpower_flag_ff && overpower_threshold_ff
         == pms_pkg::OVERPOWER_DISABLE |=> !overpower_flag_ff)
      else $error("Overpower set while disabled.");

   a_byte_in_word: assert property ( // see R3
      @(posedge clk_i) disable iff (rst_i)
      rd_en_i && cmd_i == pms_pkg::CMD_SUMMARY_STATUS_WORD ##1
         rd_en_i && cmd_i == pms_pkg::CMD_SUMMARY_STATUS_BYTE
         && $stable(summary_status_byte)
         |=> rd_data_o == {8'h00, $past(rd_data_o[7:0])})
      else $error("Summary byte differs from word low byte.");

   a_comm_latch: assert property ( // see R5
      @(posedge clk_i) disable iff (rst_i)
      comm_err_i |=> comm_error_flag_ff [*1] ##0
         summary_status_byte[pms_pkg::SUM_COMM_ERROR_BIT])
      else $error("Comm error did not latch.");

   a_pending_live: assert property ( // see R6
      @(posedge clk_i) disable iff (rst_i)
      rd_en_i && cmd_i == pms_pkg::CMD_SUMMARY_STATUS_BYTE
         |=> rd_data_o[0] == ($past(overcurrent_flag_ff)
         || $past(overpower_flag_ff) || $past(primary_overvoltage_flag_ff)
         || $past(primary_undervoltage_flag_ff)
         || $past(aux_overvoltage_flag_ff)
         || $past(aux_undervoltage_flag_ff)))
      else $error("Pending bit does not match status registers.");

   a_word_rollup: assert property ( // see R7
      @(posedge clk_i) disable iff (rst_i)
      rd_en_i && cmd_i == pms_pkg::CMD_SUMMARY_STATUS_WORD |=>
         rd_data_o[14] == $past(overcurrent_flag_ff)
         && rd_data_o[12] == ($past(aux_overvoltage_flag_ff)
         || $past(aux_undervoltage_flag_ff)))
      else $error("Word roll-up bits wrong.");

   a_word_reserved: assert property ( // see R10
      @(posedge clk_i) disable iff (rst_i)
      rd_valid_o && rd_cmd_ff == pms_pkg::CMD_SUMMARY_STATUS_WORD
         |-> rd_data_o[15] == 1'b0 && rd_data_o[11:8] == 4'h0
         && rd_data_o[7:2] == 6'h00)
      else $error("Reserved word bits not zero.");

   a_input_reserved: assert property ( // see R15
      @(posedge clk_i) disable iff (rst_i)
      rd_valid_o && rd_cmd_ff == pms_pkg::CMD_INPUT_WARNING_STATUS
         |-> rd_data_o[7] == 1'b0 && rd_data_o[4:1] == 4'h0)
      else $error("Reserved input bits not zero.");

   a_oc_latch: assert property ( // see R11
      @(posedge clk_i) disable iff (rst_i)
      overcurrent_event |=> overcurrent_flag_ff)
      else $error("Overcurrent did not latch.");

   a_vin_latch: assert property ( // see R12
      @(posedge clk_i) disable iff (rst_i)
      sample_valid_i && primary_overvoltage_threshold_i != 12'hfff
         && primary_voltage_i > primary_overvoltage_threshold_i
         |=> input_warning_status[6])
      else $error("Overvoltage did not latch.");

   a_uv_latch: assert property ( // see R13
      @(posedge clk_i) disable iff (rst_i)
      sample_valid_i && primary_voltage_i < primary_undervoltage_threshold_i
         |=> input_warning_status[5])
      else $error("Undervoltage did not latch.");

   a_flag_holds: assert property ( // see R19
      @(posedge clk_i) disable iff (rst_i)
      (overcurrent_flag_ff && !clear_faults) [*2] |=> overcurrent_flag_ff)
      else $error("Latched flag dropped without clear.");

   a_clear_all: assert property ( // see R16
      @(posedge clk_i) disable iff (rst_i)
      clear_faults && !sample_valid_i && !comm_err_i
         |=> summary_status_word == 16'h0000)
      else $error("Clear-faults left a bit set.");

endmodule : pms_status_flags

// *** power_monitor_status_flags_test.sv ***
// Purpose: Self-checking bench of the power monitor status flags.
// Assumes: Reads answer one cycle after the strobe.
// Notes: Expected words are worked out from the bit map by hand.
`timescale 1ns/100ps
module power_monitor_status_flags_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] cmd;
   logic wr_en, rd_en, comm_err, smp;
   logic [15:0] wr_data, pwr, rd_data;
   logic [11:0] cur, primary_voltage, aux, oc_thr, ov_thr, uv_thr, aov_thr, auv_thr;
   logic rd_valid, rd_hit;
   int tests_run = 0;
   int n_mismatch = 0;
   int cyc = 0;

   always #10 clk = ~clk;

   pms_status_flags i_pms_status_flags (
      .clk_i(clk), .rst_i(rst), .cmd_i(cmd), .wr_en_i(wr_en),
      .wr_data_i(wr_data), .rd_en_i(rd_en), .comm_err_i(comm_err),
      .sample_valid_i(smp), .sensed_current_i(cur),
      .primary_voltage_i(primary_voltage), .power_i(pwr), .auxiliary_voltage_i(aux),
      .overcurrent_threshold_i(oc_thr),
      .primary_overvoltage_threshold_i(ov_thr),
      .primary_undervoltage_threshold_i(uv_thr),
      .aux_overvoltage_threshold_i(aov_thr),
      .aux_undervoltage_threshold_i(auv_thr),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_hit_o(rd_hit));

   pms_host_model i_pms_host_model (
      .clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .rd_hit_i(rd_hit), .cmd_o(cmd), .wr_en_o(wr_en),
      .wr_data_o(wr_data), .rd_en_o(rd_en), .comm_err_o(comm_err));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   // The whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] c, input logic [15:0] exp,
         input logic hx = 1'b1);
      logic [15:0] d;
      logic v;
      logic h;
      i_pms_host_model.reg_read(c, d, v, h);
      chk({15'h0000, v}, 16'h0001);
      chk(d, exp);
      chk({15'h0000, h}, {15'h0000, hx});
   endtask : rd

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      i_pms_host_model.reg_write(c, d);
   endtask : wr

   task automatic meas(input logic [11:0] c, input logic [11:0] v,
         input logic [15:0] p, input logic [11:0] a);
      @(posedge clk);
      cur <= c;
      primary_voltage <= v;
      pwr <= p;
      aux <= a;
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
   endtask : meas

   task automatic t_reset();
      rd(8'h6b, 16'h7fff);
      rd(8'h78, 16'h0000);
      rd(8'h79, 16'h0000);
      rd(8'h7b, 16'h0000);
      rd(8'h7c, 16'h0000);
      rd(8'h80, 16'h0000);
      rd(8'h55, 16'h0000, 1'b0);
      meas(12'h000, 12'h400, 16'h7fff, 12'h400);
      rd(8'h7c, 16'h0000);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_power();
      wr(8'h6b, 16'h0100);
      rd(8'h6b, 16'h0100);
      meas(12'h000, 12'h400, 16'h0100, 12'h400);
      rd(8'h7c, 16'h0000);
      meas(12'h000, 12'h400, 16'h0101, 12'h400);
      rd(8'h7c, 16'h0001);
      rd(8'h79, 16'h2001);
      rd(8'h78, 16'h0001);
      meas(12'h000, 12'h400, 16'h0000, 12'h400);
      rd(8'h7c, 16'h0001);
      wr(8'h03, 16'h0000);
      rd(8'h79, 16'h0000);
      wr(8'h6b, 16'hff00);
      meas(12'h000, 12'h400, 16'hff01, 12'h400);
      rd(8'h7c, 16'h0000);
      meas(12'h000, 12'h400, 16'hfeff, 12'h400);
      rd(8'h7c, 16'h0001);
      wr(8'h6b, 16'h7fff);
      wr(8'h03, 16'h0000);
      meas(12'h000, 12'h400, 16'h8000, 12'h400);
      rd(8'h7c, 16'h0000);
      $display("t_power done");
   endtask : t_power

   task automatic t_current();
      @(posedge clk);
      oc_thr <= 12'h100;
      meas(12'h100, 12'h400, 16'h0000, 12'h400);
      rd(8'h7b, 16'h0000);
      meas(12'h101, 12'h400, 16'h0000, 12'h400);
      rd(8'h7b, 16'h0020);
      rd(8'h79, 16'h4001);
      wr(8'h7b, 16'h0000);
      rd(8'h7b, 16'h0020);
      wr(8'h03, 16'h0000);
      rd(8'h79, 16'h0000);
      oc_thr <= 12'hf00;
      meas(12'hf01, 12'h400, 16'h0000, 12'h400);
      rd(8'h7b, 16'h0000);
      meas(12'heff, 12'h400, 16'h0000, 12'h400);
      rd(8'h7b, 16'h0020);
      wr(8'h03, 16'h0000);
      oc_thr <= 12'h7ff;
      $display("t_current done");
   endtask : t_current

   task automatic t_voltage();
      @(posedge clk);
      ov_thr <= 12'h800;
      uv_thr <= 12'h100;
      aov_thr <= 12'h800;
      auv_thr <= 12'h100;
      meas(12'h000, 12'h801, 16'h0000, 12'h400);
      rd(8'h7c, 16'h0040);
      wr(8'h03, 16'h0000);
      meas(12'h000, 12'h0ff, 16'h0000, 12'h400);
      rd(8'h7c, 16'h0020);
      wr(8'h03, 16'h0000);
      meas(12'h000, 12'h400, 16'h0000, 12'h801);
      rd(8'h80, 16'h0040);
      rd(8'h79, 16'h1001);
      wr(8'h03, 16'h0000);
      meas(12'h000, 12'h400, 16'h0000, 12'h0ff);
      rd(8'h80, 16'h0020);
      wr(8'h03, 16'h0000);
      rd(8'h80, 16'h0000);
      $display("t_voltage done");
   endtask : t_voltage

   task automatic t_comm();
      logic [15:0] d0;
      logic [15:0] d1;
      i_pms_host_model.bad_frame();
      rd(8'h78, 16'h0002);
      rd(8'h79, 16'h0002);
      i_pms_host_model.reg_read_pair(8'h79, 8'h78, d0, d1);
      chk(d0, 16'h0002);
      chk(d1, 16'h0002);
      rd(8'h78, 16'h0002);
      wr(8'h03, 16'h0000);
      rd(8'h78, 16'h0000);
      $display("t_comm done");
   endtask : t_comm

   initial begin
      smp = 1'b0;
      cur = 12'h000;
      primary_voltage = 12'h400;
      pwr = 16'h0000;
      aux = 12'h400;
      oc_thr = 12'h7ff;
      ov_thr = 12'hfff;
      uv_thr = 12'h000;
      aov_thr = 12'hfff;
      auv_thr = 12'h000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_power();
      t_current();
      t_voltage();
      t_comm();
      give_verdict();
   end
endmodule : power_monitor_status_flags_test
